// >>> hdl/mmx_cfg.svh
`ifndef MMX_CFG_SVH
`define MMX_CFG_SVH

// Save-area offsets of the state words written on entry
`define MMX_OFS_REVISION      16'h7EFC
`define MMX_OFS_RESTART       16'h7F00
`define MMX_OFS_IO_MEM_ADDR   16'h7FA0
`define MMX_OFS_IO_STATE      16'h7FA4

// Avalon-MM register byte addresses
`define MMX_ADR_REVISION      16'h7EFC
`define MMX_ADR_RESTART       16'h7F00
`define MMX_ADR_IO_MEM_ADDR   16'h7FA0
`define MMX_ADR_IO_STATE      16'h7FA4
`define MMX_ADR_CONTROL       16'h0000
`define MMX_ADR_STATUS        16'h0004

// I/O state word field positions
`define MMX_IOS_PORT_HI       31
`define MMX_IOS_PORT_LO       16
`define MMX_IOS_TYPE_HI       7
`define MMX_IOS_TYPE_LO       4
`define MMX_IOS_LEN_HI        3
`define MMX_IOS_LEN_LO        1
`define MMX_IOS_VALID         0

// Revision word fields
`define MMX_REV_BASE_VERSION  16'h0001
`define MMX_REV_IO_RESTART    16
`define MMX_REV_BASE_RELOC    17

// Restart field values
`define MMX_RESTART_NONE      8'h00
`define MMX_RESTART_REEXEC    8'hFF

// Unmapped read answer
`define MMX_UNMAPPED_DATA     32'h0000_0000

`endif

// >>> hdl/mmx_pkg.sv
package mmx_pkg;

	// I/O length, one-hot
	typedef enum logic [2:0] {
		MMX_LEN_BYTE  = 3'h1,
		MMX_LEN_WORD  = 3'h2,
		MMX_LEN_DWORD = 3'h4
	} mmx_len_t;

	// I/O instruction type
	typedef enum logic [3:0] {
		MMX_TYP_OUT_PORTREG = 4'h0,
		MMX_TYP_IN_PORTREG  = 4'h1,
		MMX_TYP_STR_OUT     = 4'h2,
		MMX_TYP_STR_IN      = 4'h3,
		MMX_TYP_REP_STR_OUT = 4'h6,
		MMX_TYP_REP_STR_IN  = 4'h7,
		MMX_TYP_OUT_IMM     = 4'h8,
		MMX_TYP_IN_IMM      = 4'h9
	} mmx_type_t;

	typedef enum logic [0:0] {
		MMX_ST_NORMAL = 1'b0,
		MMX_ST_MGMT   = 1'b1
	} mmx_mode_t;

	// Retired instruction report from the core
	typedef struct packed {
		logic        retire;
		logic        io_done;
		logic [15:0] port;
		logic [3:0]  io_type;
		logic [2:0]  io_len;
		logic [31:0] mem_addr;
	} mmx_retire_t;

	// Avalon-MM request
	typedef struct packed {
		logic [15:0] address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} mmx_av_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} mmx_av_rsp_t;

	// All block state
	typedef struct packed {
		mmx_mode_t   mode;
		logic [31:0] io_state;
		logic [31:0] io_mem_addr;
		logic [31:0] revision;
		logic [7:0]  restart;
		logic        io_seen;
		logic [15:0] last_port;
		logic [3:0]  last_type;
		logic [2:0]  last_len;
		logic [31:0] last_addr;
		logic        nmi_blocked;
		logic        nmi_blocked_pre;
		logic        nmi_pending;
		logic        nmi_take;
		logic        reexec;
		logic        fpu_real16;
		logic [1:0]  caps;
		logic        ack;
		logic [31:0] rdata;
	} mmx_state_t;

endpackage

// >>> hdl/mmx_mgmt.sv
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "mmx_cfg.svh"
module mmx_mgmt
	import mmx_pkg::*;
(
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	// Core events
	input  wire mmx_retire_t  retire_i,
	input  wire logic         management_interrupt_i,
	input  wire logic         resume_from_management_i,
	input  wire logic         interrupt_return_i,
	input  wire logic         nmi_i,
	input  wire logic         nmi_blocked_i,
	input  wire logic         address_line_mask_request_i,
	input  wire logic         nmi_serviced_i,
	// Core controls
	output logic              management_mode_o,
	output logic              nmi_take_o,
	output logic              nmi_pending_o,
	output logic              nmi_blocked_o,
	output logic              mgmt_irq_blocked_o,
	output logic              address_line_mask_blocked_o,
	output logic              reexec_io_o,
	output logic              fpu_real16_o,
	// Avalon-MM slave
	input  wire mmx_av_req_t  av_req_i,
	output mmx_av_rsp_t       av_rsp_o
);

	mmx_state_t s_r;
	mmx_state_t s_nxt;

	logic        entry;
	logic        in_mgmt;
	logic        io_cond;
	logic        is_string;
	logic [31:0] rd_mux;
	logic        access;

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		s_nxt     = s_r;
		in_mgmt   = (s_r.mode == MMX_ST_MGMT);
		entry     = management_interrupt_i && !in_mgmt;
		s_nxt.ack = 1'b0;
		// Track whether the latest retired instruction was a finished I/O
		if (retire_i.retire && !in_mgmt) begin
			s_nxt.io_seen   = retire_i.io_done;
			s_nxt.last_port = retire_i.port;
			s_nxt.last_type = retire_i.io_type;
			s_nxt.last_len  = retire_i.io_len;
			s_nxt.last_addr = retire_i.mem_addr;
		end
		io_cond   = s_r.io_seen;
		is_string = s_r.last_type[1];
		s_nxt.nmi_take = 1'b0;

		if (entry) begin
			s_nxt.mode     = MMX_ST_MGMT;
			s_nxt.revision = {14'h0000, s_r.caps, `MMX_REV_BASE_VERSION};
			s_nxt.restart  = `MMX_RESTART_NONE;
			if (io_cond) begin
				s_nxt.io_state = 32'h0000_0000;
				s_nxt.io_state[`MMX_IOS_PORT_HI:`MMX_IOS_PORT_LO] = s_r.last_port;
				s_nxt.io_state[`MMX_IOS_TYPE_HI:`MMX_IOS_TYPE_LO] = s_r.last_type;
				s_nxt.io_state[`MMX_IOS_LEN_HI:`MMX_IOS_LEN_LO]   = s_r.last_len;
				s_nxt.io_state[`MMX_IOS_VALID]                    = 1'b1;
				s_nxt.io_mem_addr = is_string ? s_r.last_addr : 32'h0000_0000;
			end else begin
				s_nxt.io_state    = 32'h0000_0000;
				s_nxt.io_mem_addr = 32'h0000_0000;
			end
			// Only the pre-entry external block is kept, not an in-handler NMI mask
			s_nxt.nmi_blocked_pre = nmi_blocked_i;
			s_nxt.nmi_blocked     = 1'b1;
			s_nxt.fpu_real16      = 1'b1;
			s_nxt.io_seen         = 1'b0;
		end else if (in_mgmt) begin
			if (interrupt_return_i) begin
				s_nxt.nmi_blocked = 1'b0;
			end
			if (resume_from_management_i) begin
				s_nxt.mode        = MMX_ST_NORMAL;
				s_nxt.fpu_real16  = 1'b0;
				s_nxt.reexec      = (s_r.restart == `MMX_RESTART_REEXEC);
				s_nxt.nmi_blocked = s_r.nmi_blocked_pre;
				s_nxt.nmi_take    = s_r.nmi_pending && !s_r.nmi_blocked_pre;
				if (s_nxt.nmi_take) begin
					s_nxt.nmi_pending = 1'b0;
				end
			end
		end else begin
			s_nxt.reexec = 1'b0;
			s_nxt.nmi_blocked = nmi_blocked_i;
		end

		// Latch one NMI while blocked or in management mode; a second is merged into the first
		if (nmi_i && (s_nxt.nmi_blocked || in_mgmt) && !nmi_serviced_i) begin
			s_nxt.nmi_pending = 1'b1;
		end
		if (in_mgmt && !s_r.nmi_blocked && s_r.nmi_pending && !resume_from_management_i) begin
			s_nxt.nmi_take    = 1'b1;
			s_nxt.nmi_pending = 1'b0;
		end
		if (!in_mgmt && !entry && !s_r.nmi_blocked && s_r.nmi_pending) begin
			s_nxt.nmi_take    = 1'b1;
			s_nxt.nmi_pending = 1'b0;
		end

		// Bus: one-cycle wait then answer
		access = av_req_i.read || av_req_i.write;
		case (av_req_i.address)
			`MMX_ADR_REVISION:    rd_mux = s_r.revision;
			`MMX_ADR_RESTART:     rd_mux = {24'h00_0000, s_r.restart};
			`MMX_ADR_IO_MEM_ADDR: rd_mux = s_r.io_mem_addr;
			`MMX_ADR_IO_STATE:    rd_mux = s_r.io_state;
			`MMX_ADR_CONTROL:     rd_mux = {30'h0000_0000, s_r.caps};
			`MMX_ADR_STATUS:      rd_mux = {26'h000_0000, s_r.reexec, s_r.fpu_real16, s_r.nmi_take,
			                                s_r.nmi_pending, s_r.nmi_blocked, in_mgmt};
			default:              rd_mux = `MMX_UNMAPPED_DATA;
		endcase
		if (access && !s_r.ack) begin
			s_nxt.ack   = 1'b1;
			s_nxt.rdata = rd_mux;
		end
		// Writes land only at the edge where waitrequest is seen low
		if (access && s_r.ack && av_req_i.write && av_req_i.byteenable[0]) begin
			if (av_req_i.address == `MMX_ADR_RESTART && in_mgmt) begin
				s_nxt.restart = av_req_i.writedata[7:0];
			end
			if (av_req_i.address == `MMX_ADR_CONTROL) begin
				s_nxt.caps = av_req_i.writedata[1:0];
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '{mode: MMX_ST_NORMAL, caps: 2'h3, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign management_mode_o           = (s_r.mode == MMX_ST_MGMT);
	assign mgmt_irq_blocked_o          = (s_r.mode == MMX_ST_MGMT);
	assign address_line_mask_blocked_o = (s_r.mode == MMX_ST_MGMT) && address_line_mask_request_i;
	assign nmi_take_o                  = s_r.nmi_take;
	assign nmi_pending_o               = s_r.nmi_pending;
	assign nmi_blocked_o               = s_r.nmi_blocked;
	assign reexec_io_o                 = s_r.reexec;
	assign fpu_real16_o                = s_r.fpu_real16;
	assign av_rsp_o.readdata           = s_r.rdata;
	assign av_rsp_o.waitrequest        = (av_req_i.read || av_req_i.write) && !s_r.ack;

endmodule // mmx_mgmt

// >>> testbench/mmx_mgmt_props.sv
`timescale 1ns/1ps
module mmx_mgmt_props
	import mmx_pkg::*;
(
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire logic        management_interrupt_i,
	input wire logic        resume_from_management_i,
	input wire logic        address_line_mask_request_i,
	input wire mmx_av_req_t av_req_i,
	input wire logic        management_mode_o,
	input wire logic        nmi_take_o,
	input wire logic        nmi_blocked_o,
	input wire logic        mgmt_irq_blocked_o,
	input wire logic        address_line_mask_blocked_o,
	input wire logic        fpu_real16_o,
	input wire mmx_av_rsp_t av_rsp_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	chk_entry_taken: assert property (!management_mode_o && management_interrupt_i |=> management_mode_o)
		else $error("entry missed");
	chk_mode_holds: assert property (management_mode_o && !resume_from_management_i |=> management_mode_o)
		else $error("mode left early");
	chk_fpu_real: assert property (management_mode_o |-> fpu_real16_o)
		else $error("fpu format wrong");
	chk_nmi_entry: assert property ($rose(management_mode_o) |-> nmi_blocked_o)
		else $error("nmi open on entry");
	chk_take_once: assert property (nmi_take_o |=> !nmi_take_o)
		else $error("nmi taken twice");
	chk_blocked_take: assert property (management_mode_o && nmi_blocked_o |-> !nmi_take_o)
		else $error("nmi taken while blocked");
	chk_irq_block: assert property (mgmt_irq_blocked_o == management_mode_o)
		else $error("interrupt block wrong");
	chk_mask_block: assert property (address_line_mask_blocked_o == (management_mode_o && address_line_mask_request_i))
		else $error("mask block wrong");
	chk_bus_answer: assert property ((av_req_i.read || av_req_i.write) && av_rsp_o.waitrequest |=> !av_rsp_o.waitrequest)
		else $error("bus answer late");
endmodule // mmx_mgmt_props

bind mmx_mgmt mmx_mgmt_props chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .management_interrupt_i(management_interrupt_i),
	.resume_from_management_i(resume_from_management_i), .address_line_mask_request_i(address_line_mask_request_i),
	.av_req_i(av_req_i), .management_mode_o(management_mode_o), .nmi_take_o(nmi_take_o),
	.nmi_blocked_o(nmi_blocked_o), .mgmt_irq_blocked_o(mgmt_irq_blocked_o),
	.address_line_mask_blocked_o(address_line_mask_blocked_o), .fpu_real16_o(fpu_real16_o), .av_rsp_o(av_rsp_o));

// >>> testbench/mmx_chipset_model.sv
`timescale 1ns/1ps
module mmx_chipset_model (
	input  wire logic clock_i,
	input  wire logic rst_n_i,
	input  wire logic trap_i,
	input  wire logic mode_i,
	output logic      mi_o
);
	int dly;
	// Raise the interrupt a few cycles after a trapped access, hold until taken
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mi_o <= 1'b0;
			dly = 0;
		end else if (trap_i) dly = 1 + $urandom_range(2);
		else if (dly > 1) dly--;
		else if (dly == 1) begin
			dly = 0;
			mi_o <= 1'b1;
		end else if (mode_i) mi_o <= 1'b0;
	end
endmodule // mmx_chipset_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`include "mmx_cfg.svh"
module tb_top
	import mmx_pkg::*;
;
	logic        clock_i = 0, rst_n_i = 0, resume = 0, nmi = 0, nblk = 0, a20 = 0, trap = 0, interrupt_return = 0;
	logic        mi, mode, take, pend, blko, rex, fpu, ws;
	logic [31:0] rs, rd;
	mmx_retire_t ret = '0;
	mmx_av_req_t req = '0;
	mmx_av_rsp_t rsp;
	int          failures = 0, cmp_count = 0;
	logic [3:0]  typ [8] = '{4'h9, 4'h1, 4'h8, 4'h0, 4'h3, 4'h2, 4'h7, 4'h6};
	mmx_mgmt DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .retire_i(ret), .management_interrupt_i(mi),
		.resume_from_management_i(resume), .interrupt_return_i(interrupt_return), .nmi_i(nmi), .nmi_blocked_i(nblk),
		.address_line_mask_request_i(a20), .nmi_serviced_i(1'b0), .management_mode_o(mode),
		.nmi_take_o(take), .nmi_pending_o(pend), .nmi_blocked_o(blko), .mgmt_irq_blocked_o(),
		.address_line_mask_blocked_o(), .reexec_io_o(rex), .fpu_real16_o(fpu), .av_req_i(req), .av_rsp_o(rsp));
	mmx_chipset_model chipset (.clock_i(clock_i), .rst_n_i(rst_n_i), .trap_i(trap), .mode_i(mode), .mi_o(mi));
	initial begin
		forever #12.5 clock_i = ~clock_i;
	end
	// Bus answer as it stands at the coming rising edge
	always @(negedge clock_i) begin
		ws = rsp.waitrequest;
		rs = rsp.readdata;
	end
	task automatic give_verdict;
		$display("failures=%0d cmp_count=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic av(input logic [15:0] a, input logic w, input logic [31:0] d);
		req <= '{a, !w, w, d, 4'hF};
		do @(posedge clock_i); while (ws !== 1'b0);
		rd = rs;
		req <= '0;
		@(posedge clock_i);
	endtask
	function automatic logic [31:0] exp_st(logic v, logic [15:0] p, logic [3:0] t, logic [2:0] l);
		return v ? {p, 8'h00, t, l, 1'b1} : 32'h0000_0000;
	endfunction
	initial begin
		int s;
		repeat (20000) @(posedge clock_i);
		failures++;
		give_verdict;
	end
	always @(posedge clock_i) a20 <= 1'($urandom);
	initial begin
		int s;
		logic v, n;
		logic [15:0] p;
		logic [2:0] l;
		logic [31:0] a;
		s = $urandom(93227);
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		av(16'h1000, 1'b0, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			v = (i != 3);
			n = (i % 2 == 1) && (i != 5);
			p = 16'($urandom);
			a = $urandom;
			l = 3'h1 << (i % 3);
			nblk <= (i == 5);
			ret <= '{1'b1, v, p, typ[i], l, a};
			@(posedge clock_i);
			ret <= '0;
			trap <= 1'b1;
			@(posedge clock_i);
			trap <= 1'b0;
			do @(negedge clock_i); while (mode !== 1'b1);
			chk({31'h0, fpu}, 32'h0000_0001);
			@(posedge clock_i);
			av(`MMX_ADR_IO_STATE, 1'b0, 32'h0000_0000);
			chk(rd, exp_st(v, p, typ[i], l));
			av(`MMX_ADR_IO_MEM_ADDR, 1'b0, 32'h0000_0000);
			chk(rd, (v && typ[i][1]) ? a : 32'h0000_0000);
			av(`MMX_ADR_REVISION, 1'b0, 32'h0000_0000);
			chk(rd, {16'h0003, `MMX_REV_BASE_VERSION});
			av(`MMX_ADR_RESTART, 1'b0, 32'h0000_0000);
			chk(rd, 32'h0000_0000);
			if (i == 2) av(`MMX_ADR_RESTART, 1'b1, 32'h0000_00FF);
			if (i == 6) begin
				interrupt_return <= 1'b1;
				@(posedge clock_i);
				interrupt_return <= 1'b0;
				nmi <= 1'b1;
				@(posedge clock_i);
				nmi <= 1'b0;
				@(negedge clock_i);
				chk({30'h0, blko, pend}, 32'h0000_0001);
				@(negedge clock_i);
				chk({31'h0, take}, 32'h0000_0001);
				@(posedge clock_i);
			end
			if (n) begin
				nmi <= 1'b1;
				repeat (2) @(posedge clock_i);
				nmi <= 1'b0;
				@(negedge clock_i);
				chk({30'h0, pend, take}, 32'h0000_0002);
				@(posedge clock_i);
			end
			resume <= 1'b1;
			@(posedge clock_i);
			resume <= 1'b0;
			@(negedge clock_i);
			chk({28'h0, mode, take, rex, blko}, {28'h0, 1'b0, n, i == 2, i == 5});
			@(negedge clock_i);
			chk({31'h0, take}, 32'h0000_0000);
			@(posedge clock_i);
			nblk <= 1'b0;
			repeat (2) @(posedge clock_i);
		end
		give_verdict;
	end
endmodule // tb_top
